/* File: dv/ftpc_check_props.sv */
// Purpose: port assertions for the far transfer privilege check
// Assumes: one clock domain, reset active high
// Notes:   bound into ftpc_check after the module
`timescale 1ns/1ns
`default_nettype none
module ftpc_check_props #(
    parameter int unsigned IP_W = 64
) (
    // clock, reset, register strobe
    input wire logic            i_sys_clk,
    input wire logic            i_rst,
    input wire logic            i_reg_wr,
    // request side
    input wire logic            i_req_valid,
    input wire logic [2:0]      i_req_kind,
    input wire logic [15:0]     i_req_sel,
    input wire logic [IP_W-1:0] i_req_offset,
    input wire logic            i_desc_is_code,
    input wire logic            i_desc_conforming,
    input wire logic [1:0]      i_descriptor_privilege_level,
    // answer and state
    input wire logic            o_done,
    input wire logic            o_grant,
    input wire logic            o_protection_fault,
    input wire logic            o_unsupported,
    input wire logic            o_handoff,
    input wire logic [2:0]      o_fault_cause,
    input wire logic [15:0]     o_code_sel,
    input wire logic [IP_W-1:0] o_instruction_pointer,
    input wire logic [1:0]      o_current_privilege_level
);
    logic       far_code;
    logic [1:0] level;
    logic [1:0] req_lvl;
    logic [1:0] desc_lvl;
    assign level    = o_current_privilege_level;
    assign req_lvl  = i_req_sel[1:0];
    assign desc_lvl = i_descriptor_privilege_level;
    assign far_code = i_req_valid && i_desc_is_code && (i_req_kind == 3'h1 || i_req_kind == 3'h2);

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_done_follows_req: assert property (i_req_valid |=> o_done)
        else $error("no done after request");
    a_one_answer: assert property (o_done
        |-> $onehot({o_grant, o_protection_fault, o_unsupported, o_handoff}))
        else $error("answer not one-hot");
    a_near_ptr_only: assert property (i_req_valid && i_req_kind == 3'h0
        |=> o_grant && o_instruction_pointer == $past(i_req_offset) && $stable(o_code_sel))
        else $error("near transfer wrong");
    a_nc_level_eq: assert property (far_code && !i_desc_conforming
        && desc_lvl != level |=> o_protection_fault && o_fault_cause == 3'h1)
        else $error("level check missed");
    a_nc_req_le: assert property (far_code && !i_desc_conforming
        && desc_lvl == level && req_lvl > level |=> o_protection_fault && o_fault_cause == 3'h2)
        else $error("requestor check missed");
    a_conf_lvl_le: assert property (far_code && i_desc_conforming
        |=> o_protection_fault == ($past(desc_lvl) > $past(level)))
        else $error("conforming check wrong");
    a_grant_loads: assert property (far_code
        && (i_desc_conforming ? desc_lvl <= level : (desc_lvl == level && req_lvl <= level))
        |=> o_grant && o_code_sel == {$past(i_req_sel[15:2]), $past(level)}
        && o_instruction_pointer == $past(i_req_offset))
        else $error("grant load wrong");
    a_refuse_keeps: assert property (o_protection_fault || o_unsupported || o_handoff
        |-> $stable(o_code_sel) && $stable(o_instruction_pointer))
        else $error("state moved on refusal");
    a_level_fixed: assert property (o_done && !$past(i_reg_wr)
        |-> $stable(level))
        else $error("level changed by transfer");

    c_nc_grant: cover property (far_code && !i_desc_conforming ##1 o_grant);
    c_conf_grant: cover property (far_code && i_desc_conforming && desc_lvl < level ##1 o_grant);
    c_unsup: cover property (o_unsupported);
endmodule : ftpc_check_props

bind ftpc_check ftpc_check_props #(.IP_W(IP_W)) ftpc_check_props_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_req_valid(i_req_valid),
    .i_req_kind(i_req_kind), .i_req_sel(i_req_sel), .i_req_offset(i_req_offset),
    .i_desc_is_code(i_desc_is_code), .i_desc_conforming(i_desc_conforming),
    .i_descriptor_privilege_level(i_descriptor_privilege_level), .o_done(o_done),
    .o_grant(o_grant), .o_protection_fault(o_protection_fault), .o_unsupported(o_unsupported),
    .o_handoff(o_handoff), .o_fault_cause(o_fault_cause), .o_code_sel(o_code_sel),
    .o_instruction_pointer(o_instruction_pointer),
    .o_current_privilege_level(o_current_privilege_level)
);
`default_nettype wire

/* File: dv/ftpc_check_tb_top.sv */
// Purpose: self-checking bench for the far transfer privilege check
// Assumes: register port with one-cycle read latency
// Notes:   exhaustive level sweep mixed with random kinds
`timescale 1ns/1ns
`default_nettype none
module ftpc_check_tb_top;
    localparam int unsigned IP_W  = 64;
    localparam int          LIMIT = 20000;
    logic            clk     = 1'h0;
    logic            rst     = 1'h1;
    logic [7:0]      addr    = 8'h00;
    logic [31:0]     wdata   = 32'h0000_0000;
    logic            wr      = 1'h0;
    logic            rd      = 1'h0;
    logic [31:0]     seed    = 32'h9E12_4D1D;
    logic [15:0]     cs_m    = 16'h0000;
    logic [IP_W-1:0] ip_m    = 64'h0;
    logic [2:0]      cause_m = 3'h0;
    int              error_cnt = 0;
    int              n_tests   = 0;
    int              cyc       = 0;
    logic [31:0]     rdata;
    logic            req_valid, code, conf, done, grant, fault, unsup, handoff, irq;
    logic [2:0]      req_kind, cause;
    logic [15:0]     req_sel, cs;
    logic [IP_W-1:0] req_off, ip;
    logic [1:0]      dlvl, lvl;

    always #5 clk = ~clk;

    ftpc_exec_model #(.IP_W(IP_W)) ftpc_exec_model_inst (.i_sys_clk(clk),
        .o_req_valid(req_valid), .o_req_kind(req_kind), .o_req_sel(req_sel),
        .o_req_offset(req_off), .o_desc_is_code(code), .o_desc_conforming(conf),
        .o_descriptor_privilege_level(dlvl));
    ftpc_check #(.IP_W(IP_W)) ftpc_check_inst (.i_sys_clk(clk), .i_rst(rst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_req_valid(req_valid), .i_req_kind(req_kind),
        .i_req_sel(req_sel), .i_req_offset(req_off), .i_desc_is_code(code),
        .i_desc_conforming(conf), .i_descriptor_privilege_level(dlvl), .o_done(done),
        .o_grant(grant), .o_protection_fault(fault), .o_unsupported(unsup), .o_handoff(handoff),
        .o_fault_cause(cause), .o_code_sel(cs), .o_instruction_pointer(ip),
        .o_current_privilege_level(lvl), .o_irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // {grant, fault, unsup, handoff, cause}
    function automatic logic [6:0] f_exp(input logic [2:0] k, input logic c, cf, lm,
                                         input logic [1:0] d, r, p);
        if (k == ftpc_pkg::KIND_NEAR) return 7'h40;
        if (k > 3'h2) return (lm || k > 3'h5) ? {4'h2, ftpc_pkg::CAUSE_UNSUP} : 7'h08;
        if (!c) return 7'h08;
        if (cf) return (d <= p) ? 7'h40 : {4'h4, ftpc_pkg::CAUSE_CONF_LVL};
        if (d != p) return {4'h4, ftpc_pkg::CAUSE_LVL_NE};
        if (r > p) return {4'h4, ftpc_pkg::CAUSE_REQ_GT};
        return 7'h40;
    endfunction : f_exp

    ////////////////////////////////////////////////////////////////////////
    // bus and compare tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        wr   <= 1'h0;
        rd   <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        chk(64'(rdata), 64'(e));
        @(posedge clk);
    endtask : reg_rd

    task automatic irq_chk(input int n, input logic e);
        wr <= 1'h0;
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk(64'(irq), 64'(e));
        @(posedge clk);
    endtask : irq_chk

    task automatic do_req(input logic [2:0] k, input logic c, cf, lm, input logic [1:0] d, p,
                          input logic [15:0] s, input logic [IP_W-1:0] off);
        logic [6:0] e;
        e = f_exp(k, c, cf, lm, d, s[1:0], p);
        wr <= 1'h0;
        ftpc_exec_model_inst.issue(k, s, off, c, cf, d);
        @(negedge clk);
        if (e[6] && k != ftpc_pkg::KIND_NEAR) cs_m = {s[15:2], p};
        if (e[6]) ip_m = off;
        if (e[5] || e[4]) cause_m = e[2:0];
        chk(64'({done, grant, fault, unsup, handoff}), 64'({1'h1, e[6:3]}));
        chk(64'({cs, cause, lvl}), 64'({cs_m, cause_m, p}));
        chk(ip, ip_m);
        @(posedge clk);
    endtask : do_req

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [1:0]  p;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        // reset values, 0x20 unmapped
        for (int a = 0; a < 9; a++) reg_rd(8'(a * 4), 32'h0000_0000);
        // full level sweep, random kinds and modes
        for (int i = 0; i < 512; i++)
        begin
            r = rnd();
            p = i[1:0];
            reg_wr(ftpc_pkg::REG_CTRL, {31'h0, r[0]});
            reg_wr(ftpc_pkg::REG_LEVEL, {30'h0, p});
            do_req(i[8] ? r[3:1] : 3'(i[7]) + 3'h1, (i[8] && i[7]) ? r[4] : 1'h1, i[6], r[0],
                   i[3:2], p, {r[31:18], i[5:4]}, {rnd(), rnd()});
        end
        // read-only state and pointer halves
        reg_wr(ftpc_pkg::REG_CS, 32'hFFFF_FFFF);
        reg_wr(ftpc_pkg::REG_IP_LO, 32'hFFFF_FFFF);
        reg_rd(ftpc_pkg::REG_CS, {16'h0, cs_m});
        reg_rd(ftpc_pkg::REG_IP_LO, ip_m[31:0]);
        reg_rd(ftpc_pkg::REG_IP_HI, ip_m[63:32]);
        // interrupt: raise, clear, mask
        reg_wr(ftpc_pkg::REG_MASK, 32'h0000_0002);
        irq_chk(2, 1'h1);
        reg_wr(ftpc_pkg::REG_STATUS, 32'h0000_000F);
        irq_chk(2, 1'h0);
        do_req(ftpc_pkg::KIND_NEAR, 1'h1, 1'h0, 1'h0, 2'h0, p, 16'h1234, {rnd(), rnd()});
        irq_chk(1, 1'h0);
        reg_rd(ftpc_pkg::REG_STATUS, 32'h0000_0001);
        do_req(ftpc_pkg::KIND_FAR_JMP, 1'h1, 1'h0, 1'h0, ~p, p, 16'h0040, {rnd(), rnd()});
        irq_chk(2, 1'h1);
        reg_rd(ftpc_pkg::REG_STATUS, 32'h0000_0003);
        reg_wr(ftpc_pkg::REG_STATUS, 32'h0000_0002);
        irq_chk(2, 1'h0);
        end_sim();
    end
endmodule : ftpc_check_tb_top
`default_nettype wire

/* File: dv/ftpc_exec_model.sv */
// Purpose: execution logic model issuing far and near transfers
// Assumes: issue called right after a rising edge
// Notes:   fields show inverted garbage outside a request
`timescale 1ns/1ns
`default_nettype none
module ftpc_exec_model #(
    parameter int unsigned IP_W = 64
) (
    // clock
    input wire logic             i_sys_clk,
    // request to the check unit
    output logic                 o_req_valid,
    output logic [2:0]           o_req_kind,
    output logic [15:0]          o_req_sel,
    output logic [IP_W-1:0]      o_req_offset,
    output logic                 o_desc_is_code,
    output logic                 o_desc_conforming,
    output logic [1:0]           o_descriptor_privilege_level
);
    initial
    begin
        o_req_valid       = 1'h0;
        o_req_kind        = 3'h0;
        o_req_sel         = 16'h0000;
        o_req_offset      = '0;
        o_desc_is_code    = 1'h0;
        o_desc_conforming = 1'h0;
        o_descriptor_privilege_level = 2'h0;
    end

    // one-cycle request, then fields scrambled
    task automatic issue(input logic [2:0] k, input logic [15:0] s, input logic [IP_W-1:0] off,
                         input logic c, input logic cf, input logic [1:0] d);
        o_req_valid       <= 1'h1;
        o_req_kind        <= k;
        o_req_sel         <= s;
        o_req_offset      <= off;
        o_desc_is_code    <= c;
        o_desc_conforming <= cf;
        o_descriptor_privilege_level <= d;
        @(posedge i_sys_clk);
        o_req_valid       <= 1'h0;
        o_req_kind        <= ~k;
        o_req_sel         <= ~s;
        o_req_offset      <= ~off;
        o_desc_is_code    <= ~c;
        o_desc_conforming <= ~cf;
        o_descriptor_privilege_level <= ~d;
    endtask : issue
endmodule : ftpc_exec_model
`default_nettype wire

/* File: include/ftpc_pkg.sv */
// Purpose: constants and types for the far transfer privilege check unit
// Assumes: 32-bit register port, byte offsets
// Notes:   byte offsets, control and event bit positions, and control, mask, level and code segment resets live here
package ftpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // privilege levels
    localparam int unsigned PL_W        = 2;
    localparam logic [1:0]  PL_MOST     = 2'h0;
    localparam logic [1:0]  PL_LEAST    = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // selector layout
    localparam int unsigned SEL_W       = 16;
    localparam int unsigned SEL_REQ_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_MASK    = 8'h08;
    localparam logic [7:0]  REG_LEVEL   = 8'h0C;
    localparam logic [7:0]  REG_CS      = 8'h10;
    localparam logic [7:0]  REG_IP_LO   = 8'h14;
    localparam logic [7:0]  REG_IP_HI   = 8'h18;
    localparam logic [7:0]  REG_CAUSE   = 8'h1C;

    ////////////////////////////////////////////////////////////////////////
    // control fields
    localparam int unsigned CTRL_LONG   = 0;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // event bits, shared by status and mask
    localparam int unsigned EV_W        = 4;
    localparam int unsigned EV_GRANT    = 0;
    localparam int unsigned EV_FAULT    = 1;
    localparam int unsigned EV_UNSUP    = 2;
    localparam int unsigned EV_HANDOFF  = 3;
    localparam logic [3:0]  MASK_RST    = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // reset values of the architectural state
    localparam logic [1:0]  LEVEL_RST   = 2'h0;
    localparam logic [15:0] CS_RST      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // request kinds from the execution logic
    typedef enum logic [2:0] {
        KIND_NEAR        = 3'h0,
        KIND_FAR_CALL    = 3'h1,
        KIND_FAR_JMP     = 3'h2,
        KIND_FAST_ENTRY  = 3'h3,
        KIND_FAST_EXIT   = 3'h4,
        KIND_TASK_SWITCH = 3'h5
    } ftpc_kind_t;

    ////////////////////////////////////////////////////////////////////////
    // fault causes, readable in the cause register
    typedef enum logic [2:0] {
        CAUSE_NONE       = 3'h0,
        CAUSE_LVL_NE     = 3'h1,
        CAUSE_REQ_GT     = 3'h2,
        CAUSE_CONF_LVL   = 3'h3,
        CAUSE_UNSUP      = 3'h4
    } ftpc_cause_t;

endpackage : ftpc_pkg

/* File: rtl/ftpc_check.sv */
// Purpose: privilege check on direct far calls and jumps
// Assumes: request inputs synchronous to i_sys_clk, held one cycle
// Notes:   answer is a one-cycle pulse in the cycle after the request
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - privilege levels are two bits, 0 most privileged, lower value wins
// - far call or jump to a code descriptor is checked before the target is entered, other far kinds handed off or refused
// - a granted far transfer loads selector into code segment, offset into pointer
// - near transfers update the pointer with no privilege check
// - fast system entry and exit are refused in long mode
// - hardware task switch is refused in long mode
// - far call or jump naming a code descriptor uses the direct checks
// - same-level-entry flag selects conforming or nonconforming checks
// - direct transfers never change privilege level nor switch stacks
// - nonconforming: descriptor level unequal to current level faults
// - nonconforming: requestor level above current level faults
// - nonconforming grant keeps current level, selector requestor level ignored
// - conforming: descriptor level above current level faults, else allowed
// - conforming: requestor level plays no part
// - conforming grant runs at caller level, descriptor level ignored
// - conforming grant writes current level into loaded selector requestor field
module ftpc_check #(
    parameter int unsigned IP_W = 64
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    // register port
    input  wire logic [7:0]           i_reg_addr,
    input  wire logic [31:0]          i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic      [31:0]          o_reg_rdata,
    // transfer request from execution logic
    input  wire logic                 i_req_valid,
    input  wire logic [2:0]           i_req_kind,
    input  wire logic [15:0]          i_req_sel,
    input  wire logic [IP_W-1:0]      i_req_offset,
    input  wire logic                 i_desc_is_code,
    input  wire logic                 i_desc_conforming,
    input  wire logic [1:0]           i_descriptor_privilege_level,
    // answer to execution logic
    output logic                      o_done,
    output logic                      o_grant,
    output logic                      o_protection_fault,
    output logic                      o_unsupported,
    output logic                      o_handoff,
    output logic      [2:0]           o_fault_cause,
    // architectural state
    output logic      [15:0]          o_code_sel,
    output logic      [IP_W-1:0]      o_instruction_pointer,
    output logic      [1:0]           o_current_privilege_level,
    // interrupt
    output logic                      o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ftpc_pkg::ftpc_kind_t  kind;
    ftpc_pkg::ftpc_cause_t cause_d;
    ftpc_pkg::ftpc_cause_t cause_q;

    logic [1:0]          level_q;
    logic [1:0]          req_level;
    logic [15:0]         cs_q;
    logic [IP_W-1:0]     ip_q;
    logic [31:0]         ctrl_q;
    logic [3:0]          status_q;
    logic [3:0]          mask_q;
    logic [3:0]          ev_d;
    logic [3:0]          ev_q;
    logic                long_mode;
    logic                is_far;
    logic                grant_d;
    logic                fault_d;
    logic                unsup_d;
    logic                handoff_d;
    logic                near_d;
    logic [15:0]         sel_load;
    logic [63:0]         ip_wide;
    logic [31:0]         rdata_d;

    assign kind      = ftpc_pkg::ftpc_kind_t'(i_req_kind);
    assign long_mode = ctrl_q[ftpc_pkg::CTRL_LONG];
    assign req_level = i_req_sel[ftpc_pkg::SEL_REQ_LSB +: ftpc_pkg::PL_W];
    assign is_far    = (kind == ftpc_pkg::KIND_FAR_CALL) || (kind == ftpc_pkg::KIND_FAR_JMP);

    ////////////////////////////////////////////////////////////////////////
    // privilege decision
    always_comb
    begin
        grant_d   = 1'b0;
        fault_d   = 1'b0;
        unsup_d   = 1'b0;
        handoff_d = 1'b0;
        near_d    = 1'b0;
        cause_d   = ftpc_pkg::CAUSE_NONE;
        if (i_req_valid)
        begin
            case (kind)
                ftpc_pkg::KIND_NEAR:
                begin
                    near_d = 1'b1;
                end
                ftpc_pkg::KIND_FAR_CALL,
                ftpc_pkg::KIND_FAR_JMP:
                begin
                    if (!i_desc_is_code)
                    begin
                        handoff_d = 1'b1;
                    end
                    else if (i_desc_conforming)
                    begin
                        // requestor level not consulted here
                        if (i_descriptor_privilege_level > level_q)
                        begin
                            fault_d = 1'b1;
                            cause_d = ftpc_pkg::CAUSE_CONF_LVL;
                        end
                        else
                        begin
                            grant_d = 1'b1;
                        end
                    end
                    else if (i_descriptor_privilege_level != level_q)
                    begin
                        fault_d = 1'b1;
                        cause_d = ftpc_pkg::CAUSE_LVL_NE;
                    end
                    else if (req_level > level_q)
                    begin
                        fault_d = 1'b1;
                        cause_d = ftpc_pkg::CAUSE_REQ_GT;
                    end
                    else
                    begin
                        grant_d = 1'b1;
                    end
                end
                ftpc_pkg::KIND_FAST_ENTRY,
                ftpc_pkg::KIND_FAST_EXIT:
                begin
                    if (long_mode)
                    begin
                        unsup_d = 1'b1;
                        cause_d = ftpc_pkg::CAUSE_UNSUP;
                    end
                    else
                    begin
                        handoff_d = 1'b1;
                    end
                end
                ftpc_pkg::KIND_TASK_SWITCH:
                begin
                    if (long_mode)
                    begin
                        unsup_d = 1'b1;
                        cause_d = ftpc_pkg::CAUSE_UNSUP;
                    end
                    else
                    begin
                        handoff_d = 1'b1;
                    end
                end
                default:
                begin
                    unsup_d = 1'b1;
                    cause_d = ftpc_pkg::CAUSE_UNSUP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selector image: requestor field replaced by current level
    always_comb
    begin
        sel_load = i_req_sel;
        sel_load[ftpc_pkg::SEL_REQ_LSB +: ftpc_pkg::PL_W] = level_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // code segment and instruction pointer
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cs_q <= ftpc_pkg::CS_RST;
        end
        else if (grant_d && is_far)
        begin
            cs_q <= sel_load;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ip_q <= '0;
        end
        else if ((grant_d && is_far) || near_d)
        begin
            ip_q <= i_req_offset;
        end
        // fault leaves segment and pointer alone
    end

    ////////////////////////////////////////////////////////////////////////
    // current privilege level: only software presets it
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            level_q <= ftpc_pkg::LEVEL_RST;
        end
        else if (i_reg_wr && (i_reg_addr == ftpc_pkg::REG_LEVEL))
        begin
            level_q <= i_reg_wdata[1:0];
        end
        // no transfer path writes the level
    end

    ////////////////////////////////////////////////////////////////////////
    // answer pulses
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_done             <= 1'b0;
            o_grant            <= 1'b0;
            o_protection_fault <= 1'b0;
            o_unsupported      <= 1'b0;
            o_handoff          <= 1'b0;
        end
        else
        begin
            o_done             <= i_req_valid;
            o_grant            <= grant_d | near_d;
            o_protection_fault <= fault_d;
            o_unsupported      <= unsup_d;
            o_handoff          <= handoff_d;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cause_q <= ftpc_pkg::CAUSE_NONE;
        end
        else if (fault_d || unsup_d)
        begin
            cause_q <= cause_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events: one cycle pulses into sticky status
    assign ev_d[ftpc_pkg::EV_GRANT]   = grant_d | near_d;
    assign ev_d[ftpc_pkg::EV_FAULT]   = fault_d;
    assign ev_d[ftpc_pkg::EV_UNSUP]   = unsup_d;
    assign ev_d[ftpc_pkg::EV_HANDOFF] = handoff_d;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ev_q <= '0;
        end
        else
        begin
            ev_q <= ev_d;
        end
    end

    // set wins over a write-one clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < ftpc_pkg::EV_W; g++)
        begin : g_status
            always_ff @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    status_q[g] <= 1'b0;
                end
                else if (ev_q[g])
                begin
                    status_q[g] <= 1'b1;
                end
                else if (i_reg_wr && (i_reg_addr == ftpc_pkg::REG_STATUS) && i_reg_wdata[g])
                begin
                    status_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control and mask registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q <= ftpc_pkg::CTRL_RST;
        end
        else if (i_reg_wr && (i_reg_addr == ftpc_pkg::REG_CTRL))
        begin
            ctrl_q <= {31'h0000_0000, i_reg_wdata[ftpc_pkg::CTRL_LONG]};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mask_q <= ftpc_pkg::MASK_RST;
        end
        else if (i_reg_wr && (i_reg_addr == ftpc_pkg::REG_MASK))
        begin
            mask_q <= i_reg_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe, zero otherwise
    assign ip_wide = 64'(ip_q);

    always_comb
    begin
        case (i_reg_addr)
            ftpc_pkg::REG_CTRL:   rdata_d = ctrl_q;
            ftpc_pkg::REG_STATUS: rdata_d = {28'h000_0000, status_q};
            ftpc_pkg::REG_MASK:   rdata_d = {28'h000_0000, mask_q};
            ftpc_pkg::REG_LEVEL:  rdata_d = {30'h0000_0000, level_q};
            ftpc_pkg::REG_CS:     rdata_d = {16'h0000, cs_q};
            ftpc_pkg::REG_IP_LO:  rdata_d = ip_wide[31:0];
            ftpc_pkg::REG_IP_HI:  rdata_d = ip_wide[63:32];
            ftpc_pkg::REG_CAUSE:  rdata_d = {29'h0000_0000, cause_q};
            default:              rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 32'h0000_0000;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= rdata_d;
        end
        else
        begin
            o_reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state outputs
    assign o_code_sel                = cs_q;
    assign o_instruction_pointer     = ip_q;
    assign o_current_privilege_level = level_q;
    assign o_fault_cause             = cause_q;

endmodule : ftpc_check

`default_nettype wire
